// ### hw/srtc_cfg.svh
/*
 * Constants of the seconds real-time clock: widths, limits and timing.
 * Assumes it is included by bare name from the package, not from the design files.
 */
`ifndef SRTC_CFG_SVH
`define SRTC_CFG_SVH

// Sub-second counter: 4096 ticks per second, 12 bits
`define SRTC_SUB_W 12
`define SRTC_SUB_LAST 12'hFFF
// Crystal cycles per sub-second tick (32768 / 4096)
`define SRTC_XTAL_PER_TICK 4'h8
`define SRTC_XTAL_CNT_W 4
// Trim: signed ppm, range -127..+127, one ppm per negative step, about 1/7 ppm per positive step
`define SRTC_TRIM_W 8
`define SRTC_TRIM_MAX 8'h7F
// One ppm of 32768 Hz is one cycle in a million crystal cycles
`define SRTC_PPM_WINDOW 20'hF4240
`define SRTC_WIN_W 20
// Width of the seconds count and of the sub-second alarm
`define SRTC_SEC_W 32
`define SRTC_SSA_W 32

`endif

// ### hw/srtc_pkg.sv
/*
 * Types of the seconds real-time clock.
 * Assumes srtc_cfg.svh sits in the include path.
 */
`include "srtc_cfg.svh"

package srtc_pkg;

    // One alarm's software settings
    typedef struct packed {
        logic enable;
        logic repeat_en;
        logic irq_en;
        logic wake_en;
    } srtc_alarm_cfg_t;

    // Time as seen by software
    typedef struct packed {
        logic [`SRTC_SEC_W-1:0] seconds;
        logic [`SRTC_SUB_W-1:0] subsec;
    } srtc_time_t;

    // Source of the timebase
    typedef enum logic {
        SRTC_SRC_XTAL,
        SRTC_SRC_EXT
    } srtc_src_t;

endpackage : srtc_pkg

// ### hw/srtc_sync.sv
/*
 * Two-flip-flop synchroniser for an array of level inputs.
 * Assumes the inputs are levels slower than clk_sys.
 */
module srtc_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // Per-bit two stages; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    meta_ff[i] <= 1'b0;
                    q_ff[i] <= 1'b0;
                end
                else
                begin
                    meta_ff[i] <= d[i];
                    q_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign q = q_ff;
endmodule : srtc_sync

// ### hw/srtc_top.sv
/*
 * Seconds real-time clock with a time-of-day alarm and a sub-second alarm.
 * Assumes a 32.768 kHz crystal or external clock level arrives on pins,
 * far slower than the 200 MHz clk_sys, and that software drives the
 * control ports as clk_sys levels and pulses.
 */
// Operation
// - A 32-bit count of seconds advances by one each second and is readable.
// - A time-of-day alarm fires when the seconds count reaches its set value.
// - An independent 32-bit sub-second alarm counts in 1/4096 second ticks.
// - Either alarm can repeat; the sub-second one re-arms for the same interval, the time-of-day one adds its set value to the target.
// - An enabled alarm that fires raises an interrupt and a wake-up request as its irq_en and wake_en select.
// - The timebase comes from the crystal or from a selected external clock.
// - Software trims the rate by -127 to +127: 1 ppm steps below zero, about 1/7 ppm steps above.
// - When enabled, a timebase-derived signal is driven on the calibration pin.
module srtc_top
    import srtc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic xtal_clk,
    input wire logic ext_clk,
    input wire logic rtc_enable,
    input wire srtc_src_t src_sel,
    input wire logic signed [`SRTC_TRIM_W-1:0] trim_ppm,
    input wire logic cal_out_en,
    input wire logic sec_load,
    input wire logic [`SRTC_SEC_W-1:0] sec_load_val,
    input wire logic [`SRTC_SEC_W-1:0] tod_alarm_val,
    input wire srtc_alarm_cfg_t tod_cfg,
    input wire logic [`SRTC_SSA_W-1:0] ss_alarm_val,
    input wire srtc_alarm_cfg_t ss_cfg,
    input wire logic tod_flag_clr,
    input wire logic ss_flag_clr,
    output srtc_time_t time_now,
    output logic tod_flag,
    output logic ss_flag,
    output logic rtc_irq,
    output logic rtc_wake,
    output logic rtc_cal_clock_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] pin_sync;

    srtc_sync #(
        .W(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({ext_clk, xtal_clk}),
        .q(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Timebase, trim and tick generation
    logic src_lvl;
    logic src_prev_ff, nxt_src_prev;
    logic [`SRTC_XTAL_CNT_W-1:0] div_ff, nxt_div;
    logic [`SRTC_WIN_W-1:0] win_ff, nxt_win;
    logic [`SRTC_TRIM_W-1:0] trim_left_ff, nxt_trim_left;
    logic tick_ff, nxt_tick;
    logic src_rise;
    logic [`SRTC_TRIM_W-1:0] trim_mag;

    assign src_lvl = (src_sel == SRTC_SRC_EXT) ? pin_sync[1] : pin_sync[0];
    assign src_rise = src_lvl && !src_prev_ff;
    // Clamp -128 to 127 so the range stays symmetric
    assign trim_mag = (trim_ppm < 0) ?
        ((trim_ppm == -8'sd128) ? `SRTC_TRIM_MAX : 8'(-trim_ppm)) : 8'(trim_ppm);

    // Divider: a positive trim cuts ticks to seven edges while trim_left_ff lasts, a negative one swallows edges,
    // once per million edges; exact on average for negative trims, about 1/7 of the setting for positive ones
    always_comb
    begin
        nxt_src_prev = src_lvl;
        nxt_div = div_ff;
        nxt_win = win_ff;
        nxt_trim_left = trim_left_ff;
        nxt_tick = 1'b0;
        if (rtc_enable && src_rise)
        begin
            if (win_ff == `SRTC_PPM_WINDOW - 20'h1)
            begin
                nxt_win = 20'h0;
                nxt_trim_left = trim_mag;
            end
            else
            begin
                nxt_win = win_ff + 20'h1;
            end
            if (trim_left_ff != 8'h0 && trim_ppm < 0)
            begin
                nxt_trim_left = trim_left_ff - 8'h1;
            end
            else
            begin
                if (trim_left_ff != 8'h0)
                begin
                    nxt_trim_left = trim_left_ff - 8'h1;
                end
                if (div_ff >= `SRTC_XTAL_PER_TICK - 4'h1 - 4'(trim_left_ff != 8'h0))
                begin
                    nxt_div = 4'h0;
                    nxt_tick = 1'b1;
                end
                else
                begin
                    nxt_div = div_ff + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            src_prev_ff <= 1'b0;
            div_ff <= 4'h0;
            win_ff <= 20'h0;
            trim_left_ff <= 8'h0;
            tick_ff <= 1'b0;
        end
        else
        begin
            src_prev_ff <= nxt_src_prev;
            div_ff <= nxt_div;
            win_ff <= nxt_win;
            trim_left_ff <= nxt_trim_left;
            tick_ff <= nxt_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time counters, alarms and outputs
    srtc_time_t time_ff, nxt_time;
    logic [`SRTC_SSA_W-1:0] ss_left_ff, nxt_ss_left;
    logic [`SRTC_SEC_W-1:0] tod_target_ff, nxt_tod_target;
    logic tod_armed_ff, nxt_tod_armed;
    logic ss_armed_ff, nxt_ss_armed;
    logic tod_cfg_en_ff, ss_cfg_en_ff;
    logic tod_flag_ff, nxt_tod_flag;
    logic ss_flag_ff, nxt_ss_flag;
    logic irq_ff, nxt_irq;
    logic wake_ff, nxt_wake;
    logic cal_ff, nxt_cal;
    logic tod_fire, ss_fire;
    logic sec_carry;

    assign sec_carry = tick_ff && (time_ff.subsec == `SRTC_SUB_LAST);
    // match on seconds at the carry
    assign tod_fire = tod_armed_ff && sec_carry &&
        (time_ff.seconds + 32'h1 == tod_target_ff);
    assign ss_fire = ss_armed_ff && tick_ff && (ss_left_ff <= 32'h1);

    always_comb
    begin
        nxt_time = time_ff;
        nxt_ss_left = ss_left_ff;
        nxt_tod_target = tod_target_ff;
        nxt_tod_armed = tod_armed_ff;
        nxt_ss_armed = ss_armed_ff;
        nxt_tod_flag = tod_flag_ff;
        nxt_ss_flag = ss_flag_ff;
        if (tick_ff)
        begin
            nxt_time.subsec = time_ff.subsec + 12'h1;
            if (sec_carry)
            begin
                nxt_time.seconds = time_ff.seconds + 32'h1;
            end
        end
        if (sec_load)
        begin
            nxt_time.seconds = sec_load_val;
            nxt_time.subsec = 12'h0;
        end
        // Arming on the rising edge of enable latches the alarm value
        if (tod_cfg.enable && !tod_cfg_en_ff)
        begin
            nxt_tod_target = tod_alarm_val;
            nxt_tod_armed = 1'b1;
        end
        else if (tod_fire)
        begin
            nxt_tod_target = tod_target_ff + tod_alarm_val - time_ff.seconds - 32'h1 +
                time_ff.seconds + 32'h1 - tod_alarm_val + tod_alarm_val;
            nxt_tod_armed = tod_cfg.repeat_en;
        end
        if (!tod_cfg.enable)
        begin
            nxt_tod_armed = 1'b0;
        end
        if (ss_cfg.enable && !ss_cfg_en_ff)
        begin
            nxt_ss_left = ss_alarm_val;
            nxt_ss_armed = 1'b1;
        end
        else if (tick_ff && ss_armed_ff)
        begin
            nxt_ss_left = ss_left_ff - 32'h1;
            if (ss_fire)
            begin
                nxt_ss_left = ss_alarm_val;
                nxt_ss_armed = ss_cfg.repeat_en;
            end
        end
        if (!ss_cfg.enable)
        begin
            nxt_ss_armed = 1'b0;
        end
        if (tod_flag_clr)
        begin
            nxt_tod_flag = 1'b0;
        end
        if (tod_fire)
        begin
            nxt_tod_flag = 1'b1;
        end
        if (ss_flag_clr)
        begin
            nxt_ss_flag = 1'b0;
        end
        if (ss_fire)
        begin
            nxt_ss_flag = 1'b1;
        end
        nxt_irq = (nxt_tod_flag && tod_cfg.irq_en) || (nxt_ss_flag && ss_cfg.irq_en);
        nxt_wake = (nxt_tod_flag && tod_cfg.wake_en) || (nxt_ss_flag && ss_cfg.wake_en);
        // calibration output: 1 Hz-ish half-cycle square from subsec MSB
        nxt_cal = cal_out_en && nxt_time.subsec[`SRTC_SUB_W-1];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            time_ff <= '0;
            ss_left_ff <= 32'h0;
            tod_target_ff <= 32'h0;
            tod_armed_ff <= 1'b0;
            ss_armed_ff <= 1'b0;
            tod_cfg_en_ff <= 1'b0;
            ss_cfg_en_ff <= 1'b0;
            tod_flag_ff <= 1'b0;
            ss_flag_ff <= 1'b0;
            irq_ff <= 1'b0;
            wake_ff <= 1'b0;
            cal_ff <= 1'b0;
        end
        else
        begin
            time_ff <= nxt_time;
            ss_left_ff <= nxt_ss_left;
            tod_target_ff <= nxt_tod_target;
            tod_armed_ff <= nxt_tod_armed;
            ss_armed_ff <= nxt_ss_armed;
            tod_cfg_en_ff <= tod_cfg.enable;
            ss_cfg_en_ff <= ss_cfg.enable;
            tod_flag_ff <= nxt_tod_flag;
            ss_flag_ff <= nxt_ss_flag;
            irq_ff <= nxt_irq;
            wake_ff <= nxt_wake;
            cal_ff <= nxt_cal;
        end
    end

    assign time_now = time_ff;
    assign tod_flag = tod_flag_ff;
    assign ss_flag = ss_flag_ff;
    assign rtc_irq = irq_ff;
    assign rtc_wake = wake_ff;
    assign rtc_cal_clock_out = cal_ff;
endmodule : srtc_top

// ### test/srtc_osc_model.sv
/* Free-running crystal and external timebase levels.
   Assumes 1 ns units; periods shrunk so one second fits the run. */
module srtc_osc_model #(
    parameter real XP = 15.0,
    parameter real EP = 25.0
) (
    output logic xtal_clk,
    output logic ext_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    // both sources run free, off the clk_sys edges
    initial
    begin
        xtal_clk = 1'b0;
        #1.1;
        forever #(XP / 2.0) xtal_clk = ~xtal_clk;
    end
    initial
    begin
        ext_clk = 1'b0;
        #1.1;
        forever #(EP / 2.0) ext_clk = ~ext_clk;
    end
endmodule : srtc_osc_model

// ### test/srtc_monitor.sv
/* Port checker of the clock block.
   Assumes it is bound into srtc_top, one clk_sys domain. */
module srtc_monitor
    import srtc_pkg::*;
(
    input logic clk_sys,
    input logic rst,
    input logic rtc_enable,
    input logic cal_out_en,
    input logic sec_load,
    input srtc_alarm_cfg_t tod_cfg,
    input srtc_alarm_cfg_t ss_cfg,
    input logic tod_flag_clr,
    input logic ss_flag_clr,
    input srtc_time_t time_now,
    input logic tod_flag,
    input logic ss_flag,
    input logic rtc_irq,
    input logic rtc_wake,
    input logic rtc_cal_clock_out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // Time moves only by one tick unless loaded
    chk_sub_step: assert property (
        $changed(time_now) && !$past(sec_load) |->
        time_now.subsec == $past(time_now.subsec) + 12'h001) else $error("bad tick step");
    chk_sec_carry: assert property (
        $changed(time_now.seconds) && !$past(sec_load) |-> $past(time_now.subsec) == 12'hFFF
        && time_now.seconds == $past(time_now.seconds) + 32'h1) else $error("bad carry");
    // Pipeline is two deep, so four low cycles more than suffice to freeze time
    chk_tick_gate: assert property (
        !rtc_enable && !$past(rtc_enable) && !$past(rtc_enable, 2) && !$past(rtc_enable, 3)
        && !$past(sec_load) |-> $stable(time_now)) else $error("tick while off");
    chk_irq_raise: assert property (
        tod_flag && $past(tod_flag) && tod_cfg.enable && tod_cfg.irq_en && $stable(tod_cfg)
        |-> rtc_irq) else $error("irq missing");
    chk_wake_raise: assert property (
        ss_flag && $past(ss_flag) && ss_cfg.enable && ss_cfg.wake_en && $stable(ss_cfg)
        |-> rtc_wake) else $error("wake missing");
    chk_tod_sticky: assert property (
        $fell(tod_flag) |-> $past(tod_flag_clr)) else $error("tod flag lost");
    chk_ss_sticky: assert property (
        $fell(ss_flag) |-> $past(ss_flag_clr)) else $error("ss flag lost");
    chk_cal_track: assert property (
        $past(cal_out_en) && $stable(time_now) |-> rtc_cal_clock_out == time_now.subsec[11])
        else $error("cal pin wrong");
    cover property ($rose(tod_flag));
    cover property ($rose(ss_flag));
    cover property ($changed(time_now.seconds));
endmodule : srtc_monitor

bind srtc_top srtc_monitor u_srtc_monitor (.clk_sys(clk_sys), .rst(rst),
    .rtc_enable(rtc_enable), .cal_out_en(cal_out_en), .sec_load(sec_load),
    .tod_cfg(tod_cfg), .ss_cfg(ss_cfg), .tod_flag_clr(tod_flag_clr),
    .ss_flag_clr(ss_flag_clr), .time_now(time_now), .tod_flag(tod_flag), .ss_flag(ss_flag),
    .rtc_irq(rtc_irq), .rtc_wake(rtc_wake), .rtc_cal_clock_out(rtc_cal_clock_out));

// ### test/srtc_top_bench.sv
/* Bench of the clock block: rates, gating, both alarms, carry and wrap.
   Assumes srtc_osc_model drives the timebase pins; trim is left at zero. */
module srtc_top_bench
    import srtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic xtal_clk, ext_clk, tod_flag, ss_flag, rtc_irq, rtc_wake, rtc_cal_clock_out;
    logic rtc_enable = 1'b0;
    srtc_src_t src_sel = SRTC_SRC_XTAL;
    logic cal_out_en = 1'b0;
    logic sec_load = 1'b0;
    logic [31:0] sec_load_val = 32'h0;
    logic [31:0] tod_alarm_val = 32'h0;
    logic [31:0] ss_alarm_val = 32'h0;
    srtc_alarm_cfg_t tod_cfg = 4'h0;
    srtc_alarm_cfg_t ss_cfg = 4'h0;
    logic signed [7:0] trim_ppm = 8'sh00;
    logic tod_flag_clr = 1'b0;
    logic ss_flag_clr = 1'b0;
    srtc_time_t time_now;
    int n_fail = 0;
    int cmp_count = 0;
    srtc_osc_model u_srtc_osc_model (.xtal_clk(xtal_clk), .ext_clk(ext_clk));
    srtc_top u_srtc_top (.clk_sys(clk_sys), .rst(rst), .xtal_clk(xtal_clk), .ext_clk(ext_clk),
        .rtc_enable(rtc_enable), .src_sel(src_sel), .trim_ppm(trim_ppm), .cal_out_en(cal_out_en),
        .sec_load(sec_load), .sec_load_val(sec_load_val), .tod_alarm_val(tod_alarm_val),
        .tod_cfg(tod_cfg), .ss_alarm_val(ss_alarm_val), .ss_cfg(ss_cfg),
        .tod_flag_clr(tod_flag_clr), .ss_flag_clr(ss_flag_clr), .time_now(time_now),
        .tod_flag(tod_flag), .ss_flag(ss_flag), .rtc_irq(rtc_irq), .rtc_wake(rtc_wake),
        .rtc_cal_clock_out(rtc_cal_clock_out));
    always #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [43:0] seen, input logic [43:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("fails %0d of %0d compares", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    // Bounded waits: a lost tick or flag shows as a mismatch
    task automatic wait_tick;
        srtc_time_t t0;
        t0 = time_now;
        for (int i = 0; i < 200 && time_now === t0; i++) @(negedge clk_sys);
        // A tick that never comes counts as a mismatch
        if (time_now === t0)
            n_fail++;
    endtask : wait_tick
    task automatic wait_flag(input logic tod);
        for (int i = 0; i < 100000 && (tod ? tod_flag : ss_flag) !== 1'b1; i++)
            @(negedge clk_sys);
        check(tod ? tod_flag : ss_flag, 1'b1);
    endtask : wait_flag
    task automatic pulse_clr(input logic tod);
        tod_flag_clr = tod;
        ss_flag_clr = !tod;
        @(negedge clk_sys);
        tod_flag_clr = 1'b0;
        ss_flag_clr = 1'b0;
        @(negedge clk_sys);
    endtask : pulse_clr
    // Eight source edges per tick: 24 cycles on crystal, 40 on external
    task automatic t_rate;
        time t;
        logic [11:0] s;
        cal_out_en = 1'b1;
        rtc_enable = 1'b1;
        wait_tick;
        s = time_now.subsec;
        t = $time;
        wait_tick;
        check(44'(($time - t) / 5), 44'h18);
        check(time_now.subsec, 12'(s + 12'h001));
        src_sel = SRTC_SRC_EXT;
        wait_tick;
        wait_tick;
        t = $time;
        wait_tick;
        check(44'(($time - t) / 5), 44'h28);
        src_sel = SRTC_SRC_XTAL;
        rtc_enable = 1'b0;
        repeat (8) @(negedge clk_sys);
        s = time_now.subsec;
        repeat (100) @(negedge clk_sys);
        check(time_now.subsec, s);
        rtc_enable = 1'b1;
    endtask : t_rate
    // Sub-second alarm: fire, hold, repeat, then disarm
    task automatic t_ss;
        logic [11:0] s;
        ss_alarm_val = 32'h00000005;
        wait_tick;
        repeat (4) @(negedge clk_sys);
        s = time_now.subsec;
        ss_cfg = 4'hE;
        wait_flag(1'b0);
        check(time_now.subsec, 12'(s + 12'h005));
        check({rtc_irq, rtc_wake}, 2'b10);
        wait_tick;
        check(ss_flag, 1'b1);
        pulse_clr(1'b0);
        check({ss_flag, rtc_irq}, 2'b00);
        ss_cfg = 4'hD;
        wait_flag(1'b0);
        check(time_now.subsec, 12'(s + 12'h00A));
        check({rtc_irq, rtc_wake}, 2'b01);
        ss_cfg = 4'h0;
        pulse_clr(1'b0);
        repeat (300) @(negedge clk_sys);
        check(ss_flag, 1'b0);
    endtask : t_ss
    // Alarm one second ahead, across the all-ones wrap
    task automatic t_tod;
        sec_load_val = 32'hFFFFFFFF;
        sec_load = 1'b1;
        @(negedge clk_sys);
        sec_load = 1'b0;
        check(time_now, {32'hFFFFFFFF, 12'h000});
        tod_cfg = 4'hB;
        wait_flag(1'b1);
        check(time_now, 44'h0);
        check({rtc_irq, rtc_wake}, 2'b11);
        wait_tick;
        check(rtc_cal_clock_out, 1'b0);
        check(tod_flag, 1'b1);
        pulse_clr(1'b1);
        check({tod_flag, rtc_irq, rtc_wake}, 3'b000);
    endtask : t_tod
    initial
    begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        check(time_now, 44'h0);
        check({tod_flag, ss_flag, rtc_irq, rtc_wake, rtc_cal_clock_out}, 5'h00);
        t_rate;
        t_ss;
        t_tod;
        finish_test;
    end
    // Watchdog: the run needs about 496 us
    initial
    begin
        #600000;
        n_fail++;
        finish_test;
    end
endmodule : srtc_top_bench
